// File: rtl/apc_params.svh
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH
// ----------------------------------------------------------------------------
// codeword layout
// ----------------------------------------------------------------------------
`define APC_CW_W        21
`define APC_INFO_W      15
`define APC_CHK_W       6
`define APC_BUS_W       16
`define APC_CW_RSV_LO   10
`define APC_CW_SEQ_LO   13
`define APC_CW_CHK_LO   15
`define APC_BUS_CHK_LO  10
// ----------------------------------------------------------------------------
// check-bit xor masks over codeword bits 14..0
// ----------------------------------------------------------------------------
`define APC_MASK0       15'h2CEF
`define APC_MASK1       15'h59DE
`define APC_MASK2       15'h1F53
`define APC_MASK3       15'h3EA6
`define APC_MASK4       15'h7D4C
`define APC_MASK5       15'h5677
// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define APC_SEQ_RST     2'h0
`define APC_CHK_EN_RST  1'b0
`define APC_EN_LAST_RST 1'b1
`endif

// File: rtl/apc_pkg.sv
`include "apc_params.svh"
package apc_pkg;
  typedef logic [1:0]  apc_seq_t;
  typedef logic [5:0]  apc_chk_t;
  typedef logic [14:0] apc_info_t;
  typedef enum logic [3:0] {
    APC_PH_IDLE   = 4'h1,
    APC_PH_CMD    = 4'h2,
    APC_PH_MSG    = 4'h4,
    APC_PH_STATUS = 4'h8
  } apc_phase_t;

  function automatic apc_chk_t apc_check(input apc_info_t cw);
    apc_chk_t c;
    c[0] = ^(cw & `APC_MASK0);
    c[1] = ^(cw & `APC_MASK1);
    c[2] = ^(cw & `APC_MASK2);
    c[3] = ^(cw & `APC_MASK3);
    c[4] = ^(cw & `APC_MASK4);
    c[5] = ^(cw & `APC_MASK5);
    return c;
  endfunction
endpackage

// File: rtl/apc_link_if.sv
`timescale 1ns/100ps
interface apc_link_if;
  logic [15:0] db_tx;
  logic        strobe_tx;
  logic        run_start;
  modport sender   (output db_tx, output strobe_tx, output run_start);
  modport receiver (input db_tx, input strobe_tx, input run_start);
endinterface

// File: rtl/apc_tx_end.sv
`timescale 1ns/100ps
`include "apc_params.svh"
module apc_tx_end
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  // user side
  input  wire logic       send_i,
  input  wire logic [7:0] byte_i,
  input  wire apc_phase_t phase_i,
  input  wire logic       wide_i,
  input  wire logic       retry_i,
  // link
  apc_link_if.sender      link
);
  apc_seq_t   run_word_counter_reg;
  apc_phase_t phase_reg;
  apc_info_t  cw;
  logic       protected_ph;
  logic       new_run;
  logic       run_pend_reg;
  logic       run_first;

  assign protected_ph = (phase_i != APC_PH_IDLE);
  assign new_run      = (phase_i != phase_reg) || retry_i;
  // a phase change seen between words is held until the next word goes out
  assign run_first    = new_run || run_pend_reg;

  // --------------------------------------------------------------------------
  // codeword assembly
  // --------------------------------------------------------------------------
  always_comb begin
    cw        = '0;
    cw[7:0]   = byte_i;
    cw[9:8]   = 2'h0;
    cw[12:10] = 3'h0;
    cw[14:13] = run_first ? `APC_SEQ_RST : run_word_counter_reg;
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      phase_reg <= APC_PH_IDLE;
    end else if (ce_i) begin
      phase_reg <= phase_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      run_pend_reg <= 1'b1;
    end else if (ce_i) begin
      if (send_i) begin
        run_pend_reg <= 1'b0;
      end else if (new_run) begin
        run_pend_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      run_word_counter_reg <= `APC_SEQ_RST;
    end else if (ce_i) begin
      if (send_i && protected_ph) begin
        run_word_counter_reg <= cw[14:13] + 2'h1;
      end else if (new_run) begin
        run_word_counter_reg <= `APC_SEQ_RST;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      link.db_tx     <= 16'h0000;
      link.strobe_tx <= 1'b0;
      link.run_start <= 1'b0;
    end else if (ce_i) begin
      link.strobe_tx <= send_i;
      link.run_start <= send_i && run_first;
      if (send_i) begin
        link.db_tx[7:0]   <= byte_i;
        link.db_tx[9:8]   <= 2'h0;
        // check byte goes out whether or not the far end checks it
        link.db_tx[15:10] <= (protected_ph && wide_i) ? apc_check(cw) : 6'h00;
      end
    end
  end
endmodule

// File: rtl/apc_rx_end.sv
`timescale 1ns/100ps
`include "apc_params.svh"
module apc_rx_end
  import apc_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       ce_i,
  // mode control
  input  wire logic       wide_i,
  input  wire logic       enable_i,
  input  wire logic       port_reset_i,
  input  wire logic       xcvr_change_i,
  input  wire logic       iu_xfer_i,
  input  wire apc_phase_t phase_i,
  // link
  apc_link_if.receiver    link,
  // user side
  output logic            valid_o,
  output logic [7:0]      byte_o,
  output logic            err_o,
  output logic            chk_en_o
);
  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  // one xor mask per check bit; mask i picks the codeword bits of check bit i
  localparam logic [5:0][14:0] CHK_MASK = {
    `APC_MASK5,
    `APC_MASK4,
    `APC_MASK3,
    `APC_MASK2,
    `APC_MASK1,
    `APC_MASK0
  };

  logic [15:0] db_s1_reg;
  logic [15:0] db_s2_reg;
  logic        stb_s1_reg;
  logic        stb_s2_reg;
  logic        stb_s3_reg;
  logic        rs_s1_reg;
  logic        rs_s2_reg;
  logic        en_last_reg;
  apc_seq_t    run_word_counter_reg;
  apc_info_t   cw;
  apc_chk_t    syn;
  logic        take;
  logic        bad;
  logic        protected_ph;
  logic        err_next;

  // --------------------------------------------------------------------------
  // phase qualifier
  // --------------------------------------------------------------------------
  // data phases never reach this block; idle stands in for them
  assign protected_ph = (phase_i != APC_PH_IDLE);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  // data lines only move with a new strobe, so both stages hold a settled word
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      db_s1_reg <= 16'h0000;
      db_s2_reg <= 16'h0000;
    end else if (ce_i) begin
      db_s1_reg <= link.db_tx;
      db_s2_reg <= db_s1_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      stb_s1_reg <= 1'b0;
      stb_s2_reg <= 1'b0;
      stb_s3_reg <= 1'b0;
    end else if (ce_i) begin
      stb_s1_reg <= link.strobe_tx;
      stb_s2_reg <= stb_s1_reg;
      stb_s3_reg <= stb_s2_reg;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rs_s1_reg <= 1'b0;
      rs_s2_reg <= 1'b0;
    end else if (ce_i) begin
      rs_s1_reg <= link.run_start;
      rs_s2_reg <= rs_s1_reg;
    end
  end

  // one word per strobe pulse; strobes on adjacent cycles would merge into one
  assign take = stb_s2_reg && !stb_s3_reg;

  // --------------------------------------------------------------------------
  // codeword capture
  // --------------------------------------------------------------------------
  // the sequence bits never travel on the wires; this end's own count stands in
  always_comb begin
    cw        = '0;
    cw[7:0]   = db_s2_reg[7:0];
    cw[9:8]   = db_s2_reg[9:8];
    cw[12:10] = 3'h0;
    cw[14:13] = rs_s2_reg ? `APC_SEQ_RST : run_word_counter_reg;
  end

  // --------------------------------------------------------------------------
  // check bits and syndrome
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `APC_CHK_W; gi = gi + 1) begin : g_syn
      assign syn[gi] = (^(cw & CHK_MASK[gi])) ^ db_s2_reg[`APC_BUS_CHK_LO + gi];
    end
  endgenerate

  // a slipped run counter lands here as an ordinary code mismatch
  assign bad = |syn;

  // --------------------------------------------------------------------------
  // run counter
  // --------------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      run_word_counter_reg <= `APC_SEQ_RST;
    end else if (ce_i) begin
      if (take && protected_ph) begin
        run_word_counter_reg <= cw[14:13] + 2'h1;
      end else if (rs_s2_reg) begin
        run_word_counter_reg <= `APC_SEQ_RST;
      end
    end
  end

  // --------------------------------------------------------------------------
  // checking enable
  // --------------------------------------------------------------------------
  // reset leaves this high, so an enable held through a reset does not re-arm
  // checking; a fresh enable request is needed after every disabling event
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      en_last_reg <= `APC_EN_LAST_RST;
    end else if (ce_i) begin
      en_last_reg <= enable_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      chk_en_o <= `APC_CHK_EN_RST;
    end else if (ce_i) begin
      if (port_reset_i || xcvr_change_i) begin
        chk_en_o <= 1'b0;
      end else if (!enable_i || !wide_i) begin
        chk_en_o <= 1'b0;
      end else if (!en_last_reg) begin
        chk_en_o <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // byte delivery
  // --------------------------------------------------------------------------
  always_comb begin
    err_next = 1'b0;
    if (take && protected_ph && !iu_xfer_i) begin
      err_next = bad && chk_en_o;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      err_o   <= 1'b0;
    end else if (ce_i) begin
      valid_o <= take;
      err_o   <= err_next;
    end
  end

  // byte lines hold the last word between transfers
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      byte_o <= 8'h00;
    end else if (ce_i && take) begin
      byte_o <= db_s2_reg[7:0];
    end
  end
endmodule

// File: tb/apc_link_properties.sv
`timescale 1ns/100ps
module apc_link_properties (
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  input wire logic [15:0] db_tx,
  input wire logic        strobe_tx,
  input wire logic        run_start
);
  // ------------------------------------------------------------
  // run counter mirror and code
  // ------------------------------------------------------------
  logic [1:0] seq_reg;
  logic [1:0] cur;
  assign cur = run_start ? 2'h0 : seq_reg;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) seq_reg <= 2'h0;
    else if (strobe_tx && ce_i) seq_reg <= cur + 2'h1;
  end
  function automatic logic [5:0] ck(input logic [14:0] w);
    return {^(w & 15'h5677), ^(w & 15'h7D4C), ^(w & 15'h3EA6),
            ^(w & 15'h1F53), ^(w & 15'h59DE), ^(w & 15'h2CEF)};
  endfunction
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  property p_rsv; strobe_tx |-> db_tx[9:8] == 2'h0; endproperty
  property p_code; strobe_tx && db_tx[15:10] != 6'h0 |->
    db_tx[15:10] == ck({cur, 3'h0, db_tx[9:0]}); endproperty
  property p_first; run_start && db_tx[15:10] != 6'h0 |->
    db_tx[15:10] == ck({5'h00, db_tx[9:0]}); endproperty
  property p_pulse; strobe_tx && ce_i |=> !strobe_tx; endproperty
  property p_run; run_start |-> strobe_tx; endproperty
  property p_rpulse; run_start && ce_i |=> !run_start; endproperty
  property p_idle; !strobe_tx |-> $stable(db_tx); endproperty
  property p_rst; $rose(resetn_i) |-> !strobe_tx && db_tx == 16'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("lines 8-9 driven");
  a_code: assert property (p_code) else $error("bad check byte");
  a_first: assert property (p_first) else $error("run not at zero");
  a_pulse: assert property (p_pulse) else $error("strobe too long");
  a_run: assert property (p_run) else $error("run start alone");
  a_rpulse: assert property (p_rpulse) else $error("run start too long");
  a_idle: assert property (p_idle) else $error("lines moved idle");
  a_rst: assert property (p_rst) else $error("link busy at reset");
  c_run: cover property (run_start);
  c_wrap: cover property (strobe_tx && cur == 2'h3);
  c_chk: cover property (strobe_tx && db_tx[15:10] != 6'h0);
endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
  import apc_pkg::*;
  logic       clock_i, resetn_i, send, retry, tw, rw, en, prst, xchg, iu, ce;
  logic       valid_o, err_o, chk_en_o;
  logic [7:0] bt, lf, byte_o;
  logic [1:0] sq;
  apc_phase_t ph;
  int         bad_count, samples_checked, cyc;
  apc_link_if link ();
  apc_tx_end apc_tx_end_inst (.clock_i, .resetn_i, .ce_i(ce), .send_i(send), .byte_i(bt),
    .phase_i(ph), .wide_i(tw), .retry_i(retry), .link(link.sender));
  apc_rx_end apc_rx_end_inst (.clock_i, .resetn_i, .ce_i(ce), .wide_i(rw), .enable_i(en),
    .port_reset_i(prst), .xcvr_change_i(xchg), .iu_xfer_i(iu), .phase_i(ph),
    .link(link.receiver), .valid_o, .byte_o, .err_o, .chk_en_o);
  apc_link_properties apc_link_properties_inst (.clock_i, .resetn_i, .db_tx(link.db_tx),
    .strobe_tx(link.strobe_tx), .run_start(link.run_start), .ce_i(ce));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  function automatic logic [5:0] ck(input logic [14:0] w);
    return {^(w & 15'h5677), ^(w & 15'h7D4C), ^(w & 15'h3EA6),
            ^(w & 15'h1F53), ^(w & 15'h59DE), ^(w & 15'h2CEF)};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i) #1;
  endtask
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one word end to end; a missing check byte only errs when checking is live
  task automatic xfer(input logic on, input logic r);
    logic [7:0] b;
    logic       e;
    int         n;
    b = rnd();
    if (r) sq = 2'h0;
    e = on && !tw && ck({sq, 5'h00, b}) != 6'h0;
    sq = sq + 2'h1;
    tick(1);
    send = 1'b1;
    bt = b;
    retry = r;
    tick(1);
    send = 1'b0;
    retry = 1'b0;
    n = 0;
    while (valid_o !== 1'b1 && n < 10) begin
      tick(1);
      n++;
    end
    cmp("valid", 8'h1, {7'h0, valid_o});
    cmp("byte", b, byte_o);
    cmp("err", {7'h0, e}, {7'h0, err_o});
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    {send, retry, prst, xchg, iu, resetn_i, bt, sq} = '0;
    {tw, rw, en, ce} = 4'hD;
    lf = 8'h1A;
    ph = APC_PH_CMD;
    tick(4);
    resetn_i = 1'b1;
    tick(3);
    cmp("chk_en", 8'h0, {7'h0, chk_en_o});
    en = 1'b1;
    tick(2);
    cmp("chk_en", 8'h1, {7'h0, chk_en_o});
    repeat (9) xfer(1'b1, 1'b0);
    $display("test run wrap done");
    ph = APC_PH_MSG;
    sq = 2'h0;
    repeat (3) xfer(1'b1, 1'b0);
    xfer(1'b1, 1'b1);
    xfer(1'b1, 1'b0);
    tick(1);
    send = 1'b1;
    bt = 8'hFF;
    tick(1);
    send = 1'b0;
    ce = 1'b0;
    tick(6);
    cmp("valid frozen", 8'h0, {7'h0, valid_o});
    ce = 1'b1;
    tick(3);
    cmp("valid", 8'h1, {7'h0, valid_o});
    cmp("byte", 8'hFF, byte_o);
    cmp("err", 8'h0, {7'h0, err_o});
    sq = sq + 2'h1;
    $display("test new runs done");
    tw = 1'b0;
    repeat (8) xfer(1'b1, 1'b0);
    iu = 1'b1;
    repeat (3) xfer(1'b0, 1'b0);
    iu = 1'b0;
    ph = APC_PH_IDLE;
    repeat (2) xfer(1'b0, 1'b0);
    $display("test error paths done");
    ph = APC_PH_CMD;
    sq = 2'h0;
    rw = 1'b0;
    tick(2);
    cmp("chk_en", 8'h0, {7'h0, chk_en_o});
    xfer(1'b0, 1'b0);
    rw = 1'b1;
    tick(2);
    cmp("chk_en rearm", 8'h0, {7'h0, chk_en_o});
    en = 1'b0;
    tick(1);
    en = 1'b1;
    tick(2);
    cmp("chk_en", 8'h1, {7'h0, chk_en_o});
    xchg = 1'b1;
    tick(1);
    xchg = 1'b0;
    tick(2);
    cmp("chk_en", 8'h0, {7'h0, chk_en_o});
    xfer(1'b0, 1'b0);
    en = 1'b0;
    tick(1);
    en = 1'b1;
    tick(2);
    cmp("chk_en", 8'h1, {7'h0, chk_en_o});
    prst = 1'b1;
    tick(1);
    prst = 1'b0;
    tick(2);
    cmp("chk_en", 8'h0, {7'h0, chk_en_o});
    $display("test disable done");
    final_report();
  end
endmodule
